// >>> design/port_ef_defines.svh
// Register map and constants of the port pin logic
//
// How it works
// - Second port has seven bidirectional pin positions
// - Direction bit one makes pin an input
// - Direction bit zero drives latch onto pin
// - Latch register reads back latched values
// - Every first and second port pin has its own direction
// - Only second port pin 7 lacks analog
// - Comparators take pins 3-6, outputs override
// - Reset leaves pins 1-6 analog, reading zero
// - Memory bus drives first port pins 6,7
// - Memory reads capture pins 6,7 regardless
// - Memory bus owns pin above everything
// - Enabled PWM channel overrides port when output
// - PWM pins optionally float during shutdown
// - Unit 2 drives pin 7, or captures it
// - PWM1 channel B on pin 6 if mapped, large package only
// - Unit 2 on pin 7 if map clear and mcu_mode set
// - Memory bus pins only on large package
// - Third port top bits are pull-up enables
// - Second port bit 0 reads as zero
`ifndef PORT_EF_DEFINES_SVH
`define PORT_EF_DEFINES_SVH
`define R_E_PINS 8'h00
`define R_E_LAT 8'h04
`define R_E_DIR 8'h08
`define R_G_PINS 8'h0C
`define R_F_PINS 8'h10
`define R_F_LAT 8'h14
`define R_F_DIR 8'h18
`define R_CMP 8'h1C
`define R_ADC 8'h20
`define R_CFG 8'h24
`define DIR_RST 8'hFF
`define ZERO8 8'h00
`define F_IMPL 8'hFE
`define F_ANALOG 8'h7E
`define F_CMP_IN 8'h78
`define CMP_OFF 3'h7
`define ADC_DIGITAL 4'hF
`define G_PU_SMALL 3'h6
`define HTRANS_ACT 1
`endif

// >>> design/port_ef_pkg.sv
// Types shared by the port pin logic
package port_ef_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } ahb_req_t;
    typedef struct packed {
        logic shdn_hiz;
        logic mcu_mode;
        logic large_pkg;
        logic unit2_map;
        logic pwm_map;
    } pin_cfg_t;
    typedef struct packed {
        logic active;
        logic drive;
        logic [1:0] ad_out;
    } extmem_t;
    typedef struct packed {
        logic pwm1_b_en;
        logic pwm1_b;
        logic pwm2_a_en;
        logic pwm2_a;
        logic ccp2_en;
        logic ccp2_out;
        logic shutdown;
    } pwm_t;
endpackage

// >>> design/port_ef_pins.sv
// Pin logic of first port pins 6-7, second and third port, AHB-Lite registers
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "port_ef_defines.svh"
module port_ef_pins
    import port_ef_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Borrowing peripherals
    input wire extmem_t ext,
    input wire pwm_t pwm,
    input wire logic [1:0] cmp_out,
    output logic [1:0] ext_data_in,
    output logic ccp2_capture,
    // First port pins
    input wire logic [7:0] e_pin_in,
    output logic [1:0] e_pin_out,
    output logic [1:0] e_pin_oe,
    // Second port pins
    input wire logic [7:0] f_pin_in,
    output logic [7:0] f_pin_out,
    output logic [7:0] f_pin_oe,
    // Third port pins and pull-ups
    input wire logic [4:0] g_pin_in,
    output logic [2:0] pullup_en
);
    // ********************************
    // Registers
    // ********************************
    ahb_req_t req;
    logic [7:0] e_lat;
    logic [7:0] e_dir;
    logic [7:0] e_in;
    logic [7:0] f_lat;
    logic [7:0] f_dir;
    logic [7:0] f_in;
    logic [4:0] g_in;
    logic [5:0] cmp_ctl;
    logic [5:0] adc_cfg;
    pin_cfg_t cfg;
    logic [31:0] next_rdata;
    logic [7:0] next_f_in;
    logic wr;
    logic cmp_on;
    logic analog;
    logic ext_own;
    logic pwm1_own;
    logic unit2_ok;
    logic shdn_float;

    assign wr = req.valid && req.write;
    assign cmp_on = cmp_ctl[2:0] != `CMP_OFF;
    assign analog = adc_cfg[3:0] != `ADC_DIGITAL;
    assign ext_own = ext.active && cfg.large_pkg;
    assign pwm1_own = cfg.pwm_map && cfg.large_pkg && pwm.pwm1_b_en;
    assign unit2_ok = !cfg.unit2_map && cfg.mcu_mode;
    assign shdn_float = pwm.shutdown && cfg.shdn_hiz;

    // ********************************
    // Bus slave
    // ********************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req <= '0;
        end
        else if (hready)
        begin
            req.valid <= hsel && htrans[`HTRANS_ACT];
            req.write <= hwrite;
            req.addr <= haddr[7:0];
        end
    end

    // Read data is prepared in the address phase
    always_comb
    begin
        next_rdata = '0;
        unique case (haddr[7:0])
            `R_E_PINS: next_rdata[7:0] = e_in;
            `R_E_LAT: next_rdata[7:0] = e_lat;
            `R_E_DIR: next_rdata[7:0] = e_dir;
            `R_G_PINS: next_rdata[7:0] = {pullup_en, g_in};
            `R_F_PINS: next_rdata[7:0] = f_in & `F_IMPL;
            `R_F_LAT: next_rdata[7:0] = f_lat & `F_IMPL;
            `R_F_DIR: next_rdata[7:0] = f_dir & `F_IMPL;
            `R_CMP: next_rdata[7:0] = {cmp_out, cmp_ctl};
            `R_ADC: next_rdata[7:0] = {2'h0, adc_cfg};
            `R_CFG: next_rdata[7:0] = {3'h0, cfg};
            default: next_rdata = '0;
        endcase
    end

    // Zero wait states, so hreadyout never drops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[`HTRANS_ACT] && !hwrite)
            begin
                hrdata <= next_rdata;
            end
        end
    end

    // ********************************
    // Software registers
    // ********************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            e_lat <= `ZERO8;
            e_dir <= `DIR_RST;
        end
        else if (wr)
        begin
            if (req.addr == `R_E_PINS || req.addr == `R_E_LAT)
            begin
                e_lat <= hwdata[7:0];
            end
            if (req.addr == `R_E_DIR)
            begin
                e_dir <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            f_lat <= `ZERO8;
            f_dir <= `DIR_RST & `F_IMPL;
        end
        else if (wr)
        begin
            if (req.addr == `R_F_PINS || req.addr == `R_F_LAT)
            begin
                f_lat <= hwdata[7:0] & `F_IMPL;
            end
            if (req.addr == `R_F_DIR)
            begin
                f_dir <= hwdata[7:0] & `F_IMPL;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_ctl <= '0;
            adc_cfg <= '0;
            cfg <= '0;
            pullup_en <= '0;
        end
        else if (wr)
        begin
            if (req.addr == `R_CMP)
            begin
                cmp_ctl <= hwdata[5:0];
            end
            if (req.addr == `R_ADC)
            begin
                adc_cfg <= hwdata[5:0];
            end
            if (req.addr == `R_CFG)
            begin
                cfg <= hwdata[4:0];
            end
            // bit 5 absent on small package
            if (req.addr == `R_G_PINS)
            begin
                pullup_en <= cfg.large_pkg ? hwdata[7:5] : hwdata[7:5] & `G_PU_SMALL;
            end
        end
    end

    // ********************************
    // Pin sampling
    // ********************************
    // Digital inputs of analog or comparator pins read zero
    always_comb
    begin
        next_f_in = f_pin_in & `F_IMPL;
        if (analog)
        begin
            next_f_in = next_f_in & ~`F_ANALOG;
        end
        if (cmp_on)
        begin
            next_f_in = next_f_in & ~`F_CMP_IN;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            e_in <= '0;
            f_in <= '0;
            g_in <= '0;
        end
        else
        begin
            e_in <= e_pin_in;
            f_in <= next_f_in;
            g_in <= g_pin_in;
        end
    end

    // ********************************
    // First port pins 6 and 7
    // ********************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            e_pin_out[0] <= 1'b0;
            e_pin_oe[0] <= 1'b0;
        end
        else if (ext_own)
        begin
            e_pin_out[0] <= ext.ad_out[0];
            e_pin_oe[0] <= ext.drive;
        end
        else if (pwm1_own && !e_dir[6])
        begin
            e_pin_out[0] <= pwm.pwm1_b;
            e_pin_oe[0] <= !shdn_float;
        end
        else
        begin
            e_pin_out[0] <= e_lat[6];
            e_pin_oe[0] <= !e_dir[6];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            e_pin_out[1] <= 1'b0;
            e_pin_oe[1] <= 1'b0;
        end
        else if (ext_own)
        begin
            e_pin_out[1] <= ext.ad_out[1];
            e_pin_oe[1] <= ext.drive;
        end
        else if (unit2_ok && !e_dir[7] && pwm.pwm2_a_en)
        begin
            e_pin_out[1] <= pwm.pwm2_a;
            e_pin_oe[1] <= !shdn_float;
        end
        else if (unit2_ok && !e_dir[7] && pwm.ccp2_en)
        begin
            e_pin_out[1] <= pwm.ccp2_out;
            e_pin_oe[1] <= 1'b1;
        end
        else
        begin
            e_pin_out[1] <= e_lat[7];
            e_pin_oe[1] <= !e_dir[7];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_data_in <= '0;
            ccp2_capture <= 1'b0;
        end
        else
        begin
            if (ext_own && !ext.drive)
            begin
                ext_data_in <= e_pin_in[7:6];
            end
            ccp2_capture <= unit2_ok && !ext_own && e_dir[7] && e_pin_in[7];
        end
    end

    // ********************************
    // Second port pins
    // ********************************
    // seven pins, each dir, latch, level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            f_pin_out <= '0;
            f_pin_oe <= '0;
        end
        else
        begin
            f_pin_oe <= ~f_dir & `F_IMPL;
            f_pin_out <= f_lat & `F_IMPL;
            if (cmp_on)
            begin
                f_pin_out[1] <= f_dir[1] ? f_lat[1] : cmp_out[1];
                f_pin_out[2] <= f_dir[2] ? f_lat[2] : cmp_out[0];
            end
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_pin7_digital: assert property (analog && !cmp_on |=> f_in[7] == $past(f_pin_in[7]))
        else $error("Pin 7 input lost");
    a_dir_float: assert property ((f_pin_oe & $past(f_dir)) == '0)
        else $error("Input pin driven");
    a_dir_drive: assert property (!f_dir[5]
        |=> f_pin_oe[5] && f_pin_out[5] == $past(f_lat[5]))
        else $error("Output pin not latch");
    a_lat_readback: assert property (hsel && htrans[1] && !hwrite && hready
        && haddr[7:0] == `R_F_LAT |=> hrdata[7:0] == $past(f_lat))
        else $error("Latch read wrong");
    a_bit0_zero: assert property (f_lat[0] == 1'b0 && f_dir[0] == 1'b0
        && f_in[0] == 1'b0)
        else $error("Bit 0 not zero");
    a_analog_zero: assert property (analog |=> (f_in & `F_ANALOG) == '0)
        else $error("Analog pin reads");
    a_ext_owns: assert property (ext_own ##1 ext_own
        |=> e_pin_oe == {2{$past(ext.drive)}})
        else $error("Memory bus lost pin");
    a_pwm_shdn: assert property (!ext_own && pwm1_own && !e_dir[6] && shdn_float
        |=> !e_pin_oe[0])
        else $error("PWM pin not floating");
    a_ext_small: assert property (!cfg.large_pkg && !e_dir[6]
        |=> e_pin_out[0] == $past(e_lat[6]) || $past(pwm1_own))
        else $error("Memory bus on small package");
    a_cmp_over: assert property (cmp_on && !f_dir[1]
        |=> f_pin_out[1] == $past(cmp_out[1]))
        else $error("Comparator output lost");

    c_ext_read: cover property (ext_own && !ext.drive ##1 ext_own && ext.drive);
    c_pwm_pin7: cover property (unit2_ok && pwm.pwm2_a_en && !e_dir[7]);
    c_digital_f: cover property (!analog && !cmp_on && f_pin_oe != '0);
endmodule
`default_nettype wire

// >>> tb/port_far_side.sv
// Model of the circuitry outside the port pins
`timescale 1ns/1ps
`default_nettype none
module port_far_side
(
    // Pin drive from the block
    input wire logic [1:0] e_pin_out,
    input wire logic [1:0] e_pin_oe,
    input wire logic [7:0] f_pin_out,
    input wire logic [7:0] f_pin_oe,
    // Levels applied from outside to released pins
    input wire logic [7:0] e_ext,
    input wire logic [7:0] f_ext,
    // Resulting pin levels
    output logic [7:0] e_level,
    output logic [7:0] f_level
);
    // A released pin shows the outside level, never the last driven value
    always_comb
    begin
        e_level = e_ext;
        f_level = f_ext;
        for (int i = 0; i < 2; i++)
            if (e_pin_oe[i]) e_level[6 + i] = e_pin_out[i];
        for (int i = 0; i < 8; i++)
            if (f_pin_oe[i]) f_level[i] = f_pin_out[i];
    end
endmodule
`default_nettype wire

// >>> tb/test_port_e_f_pin_logic.sv
// Self-checking bench of the port pin logic
`timescale 1ns/1ps
`default_nettype none
`include "port_ef_defines.svh"
module test_port_e_f_pin_logic;
    import port_ef_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    extmem_t ext = '0;
    pwm_t pwm = '0;
    logic [1:0] cmp_out = 2'h0;
    logic [4:0] g_pin_in = 5'h00;
    logic [7:0] e_ext = 8'h00;
    logic [7:0] f_ext = 8'h00;
    logic hreadyout, hresp, ccp2_capture, rsp;
    logic [31:0] hrdata, rd;
    logic [1:0] ext_data_in, e_pin_out, e_pin_oe;
    logic [7:0] e_level, f_level, f_pin_out, f_pin_oe, lat, dir;
    logic [2:0] pullup_en;
    int err_total = 0;
    int compares = 0;

    always #12.5 hclk = ~hclk;

    port_ef_pins i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext(ext), .pwm(pwm), .cmp_out(cmp_out), .ext_data_in(ext_data_in),
        .ccp2_capture(ccp2_capture), .e_pin_in(e_level), .e_pin_out(e_pin_out),
        .e_pin_oe(e_pin_oe), .f_pin_in(f_level), .f_pin_out(f_pin_out),
        .f_pin_oe(f_pin_oe), .g_pin_in(g_pin_in), .pullup_en(pullup_en));

    port_far_side i_far (.e_pin_out(e_pin_out), .e_pin_oe(e_pin_oe),
        .f_pin_out(f_pin_out), .f_pin_oe(f_pin_oe), .e_ext(e_ext), .f_ext(f_ext),
        .e_level(e_level), .f_level(f_level));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single transfer, then an idle edge so a following read sees it
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        haddr <= 32'(a);
        htrans <= 2'b10;
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= 32'(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        rsp = hresp;
        @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(what, 32'(exp), rd);
        chk("hresp", 32'(1'b0), 32'(rsp));
    endtask

    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask

    function automatic logic [7:0] exp_oe(input logic [7:0] d);
        return ~d & `F_IMPL;
    endfunction

    function automatic logic [7:0] exp_lvl(input logic [7:0] d, l, x);
        return ((l & exp_oe(d)) | (x & ~exp_oe(d))) & `F_IMPL;
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        void'($urandom(28));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        f_ext <= 8'hFF;
        @(posedge hclk);
        rdc("e_dir", `R_E_DIR, 8'hFF);
        rdc("f_dir", `R_F_DIR, 8'hFE);
        rdc("f_pins", `R_F_PINS, 8'h80);
        rdc("hole", 8'h40, 8'h00);
        chk("f_oe", 32'(8'h00), 32'(f_pin_oe));
        $display("test reset done");
        wr(`R_CMP, 8'h07);
        wr(`R_ADC, 8'h0F);
        rdc("adc", `R_ADC, 8'h0F);
        for (int i = 0; i < 12; i++)
        begin
            lat = (i == 0) ? 8'hFF : 8'($urandom);
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            f_ext <= 8'($urandom);
            wr(i[0] ? `R_F_PINS : `R_F_LAT, lat);
            wr(`R_F_DIR, dir);
            settle();
            chk("f_oe", 32'(exp_oe(dir)), 32'(f_pin_oe));
            chk("f_out", 32'(lat & exp_oe(dir)), 32'(f_pin_out & f_pin_oe));
            rdc("f_lat", `R_F_LAT, lat & `F_IMPL);
            rdc("f_pins", `R_F_PINS, exp_lvl(dir, lat, f_ext));
        end
        $display("test digital done");
        wr(`R_CMP, 8'h00);
        wr(`R_F_DIR, 8'h00);
        for (int i = 1; i < 3; i++)
        begin
            cmp_out <= 2'(i);
            settle();
            chk("cmp_pin", 32'({cmp_out[0], cmp_out[1]}), 32'(f_pin_out[2:1]));
        end
        rdc("cmp", `R_CMP, 8'h80);
        wr(`R_F_DIR, 8'hFF);
        f_ext <= 8'hFF;
        settle();
        rdc("f_pins", `R_F_PINS, 8'h86);
        wr(`R_ADC, 8'h00);
        rdc("f_pins", `R_F_PINS, 8'h80);
        $display("test comparator done");
        wr(`R_CFG, 8'h05);
        rdc("cfg", `R_CFG, 8'h05);
        wr(`R_E_LAT, 8'h80);
        wr(`R_E_DIR, 8'h3F);
        pwm.pwm1_b_en <= 1'b1;
        pwm.pwm1_b <= 1'b1;
        settle();
        chk("e_out", 32'(2'b11), 32'(e_pin_out & e_pin_oe));
        pwm.shutdown <= 1'b1;
        wr(`R_CFG, 8'h15);
        settle();
        chk("e_oe", 32'(2'b10), 32'(e_pin_oe));
        wr(`R_E_DIR, 8'hFF);
        ext <= '{1'b1, 1'b1, 2'b01};
        settle();
        chk("e_oe", 32'(2'b11), 32'(e_pin_oe));
        chk("e_out", 32'(2'b01), 32'(e_pin_out));
        ext.drive <= 1'b0;
        e_ext <= 8'h80;
        settle();
        chk("e_oe", 32'(2'b00), 32'(e_pin_oe));
        chk("ext_in", 32'(2'b10), 32'(ext_data_in));
        ext <= '0;
        pwm <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        wr(`R_CFG, 8'h0C);
        wr(`R_E_PINS, 8'h00);
        wr(`R_E_DIR, 8'h3F);
        settle();
        chk("e_out", 32'(2'b10), 32'(e_pin_out & e_pin_oe));
        wr(`R_E_DIR, 8'hBF);
        settle();
        chk("capture", 32'(1'b1), 32'(ccp2_capture));
        wr(`R_CFG, 8'h0E);
        settle();
        chk("capture", 32'(1'b0), 32'(ccp2_capture));
        e_ext <= 8'h7F;
        settle();
        rdc("e_pins", `R_E_PINS, 8'h3F);
        rdc("e_lat", `R_E_LAT, 8'h00);
        $display("test first port done");
        g_pin_in <= 5'($urandom);
        wr(`R_CFG, 8'h04);
        wr(`R_G_PINS, 8'hE0);
        rdc("g_pins", `R_G_PINS, {3'b111, g_pin_in});
        chk("pullup", 32'(3'b111), 32'(pullup_en));
        wr(`R_CFG, 8'h00);
        wr(`R_G_PINS, 8'hE0);
        rdc("g_pins", `R_G_PINS, {3'b110, g_pin_in});
        $display("test pull-up done");
        complete_run();
    end

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge hclk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
